//--- fmpc_ctrl.sv
// Flyback controller mode and overvoltage protection sequencer.
// Assumes comparator levels already synchronous to pclk and an APB master.
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "fmpc_params.svh"

// Behaviour
// - Feedback below entry threshold enters burst, gate off.
// - Feedback back at threshold resumes switching.
// - Burst bursts use fixed peak clamp.
// - Burst entry selects lowered lockout threshold.
// - Above exit threshold restores normal lockout.
// - Lockout holds gate output low.
// - 9 kHz 50 percent jitter square wave.
// - Jitter depth defaults to 5 percent.
// - Capture sense winding at demagnetization.
// - Capture above reference flags overvoltage.
// - Trip after four consecutive flagged cycles.
// - Unflagged cycle clears the counter.
// - Auto-restart or latched chosen at build.
// - Auto-restart waits restart level then turn-on.
// - Latched keeps stopped, recycles start-up source.
// - Latch clears only below restart level.
// - Turn-on level starts operation, source off.
module fmpc_ctrl #(
  parameter bit LATCHED = 1'b0,
  parameter int OV_TRIP = `FMPC_OV_TRIP,
  parameter int HV_PERIOD = `FMPC_HV_PERIOD,
  parameter int HV_ON = `FMPC_HV_ON
) (
  // Clock, reset and clock enable.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Comparator levels from the analogue front end.
  input wire logic feedback_below_entry,
  input wire logic feedback_above_exit,
  input wire logic feedback_at_entry,
  input wire logic supply_at_turn_on,
  input wire logic supply_below_lockout,
  input wire logic supply_below_restart,
  input wire logic sense_winding_above_ref,
  input wire logic demag_strobe,
  input wire logic switch_request,
  // Outputs to gate drive and analogue blocks.
  output logic gate_drive,
  output logic peak_clamp_sel,
  output logic lowered_lockout_sel,
  output logic jitter_wave,
  output logic [7:0] jitter_depth,
  output logic hv_startup_en,
  output logic irq
);
  localparam int JIT_HALF = `FMPC_JIT_HALF;

  // ========================================================================
  // Elaboration checks.
  initial begin
    if (OV_TRIP < 1 || OV_TRIP > 15) begin
      $error("OV_TRIP out of range");
    end
    if (HV_ON < 1 || HV_ON >= HV_PERIOD || HV_PERIOD > 65535) begin
      $error("HV timing out of range");
    end
  end

  // ========================================================================
  // Input register stage, one flop per comparator level.
  logic fb_lo_r, fb_hi_r, fb_at_r, on_r, lock_r, rst_lvl_r;
  logic ov_r, demag_r, req_r;
  // Comparators are synchronous to pclk, so one stage retimes them.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fb_lo_r <= 1'b0;
      fb_hi_r <= 1'b0;
      fb_at_r <= 1'b0;
      on_r <= 1'b0;
      lock_r <= 1'b1;
      rst_lvl_r <= 1'b1;
      ov_r <= 1'b0;
      demag_r <= 1'b0;
      req_r <= 1'b0;
    end else if (clk_en) begin
      fb_lo_r <= feedback_below_entry;
      fb_hi_r <= feedback_above_exit;
      fb_at_r <= feedback_at_entry;
      on_r <= supply_at_turn_on;
      lock_r <= supply_below_lockout;
      rst_lvl_r <= supply_below_restart;
      ov_r <= sense_winding_above_ref;
      demag_r <= demag_strobe;
      req_r <= switch_request;
    end
  end

  // ========================================================================
  // Registers.
  logic [31:0] ctrl_r;
  logic [`FMPC_EV_W-1:0] irq_stat_r, mask_r, ev;
  logic [31:0] rd_nxt;
  logic wr_acc, rd_acc;
  fmpc_pkg::fmpc_state_e st_r;
  logic burst_r, ov_seen_r;
  logic [3:0] ov_cnt_r;

  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && !penable && !pwrite;

  // Read mux; unmapped addresses read zero and signal an error.
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == `FMPC_OFF_CTRL) || (a == `FMPC_OFF_STAT) ||
             (a == `FMPC_OFF_IRQ) || (a == `FMPC_OFF_MASK);
  endfunction

  always_comb begin
    rd_nxt = 32'h0000_0000;
    unique case (paddr)
      `FMPC_OFF_CTRL: rd_nxt = ctrl_r;
      `FMPC_OFF_STAT: rd_nxt = {26'h0, ov_cnt_r, burst_r,
                                (st_r == fmpc_pkg::FMPC_TRIP)};
      `FMPC_OFF_IRQ: rd_nxt = {28'h0, irq_stat_r};
      `FMPC_OFF_MASK: rd_nxt = {28'h0, mask_r};
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  // APB answer: ready in the access cycle, data loaded in setup.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped(paddr);
      if (rd_acc) begin
        prdata <= rd_nxt;
      end
    end
  end

  // Control and mask registers written in the access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `FMPC_CTRL_RST;
      mask_r <= '0;
    end else if (clk_en && wr_acc && pready) begin
      if (paddr == `FMPC_OFF_CTRL) begin
        ctrl_r <= pwdata;
      end
      if (paddr == `FMPC_OFF_MASK) begin
        mask_r <= pwdata[`FMPC_EV_W-1:0];
      end
    end
  end

  // Sticky events; a new event wins over a write-one clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_r <= '0;
    end else if (clk_en) begin
      if (wr_acc && pready && paddr == `FMPC_OFF_IRQ) begin
        irq_stat_r <= (irq_stat_r & ~pwdata[`FMPC_EV_W-1:0]) | ev;
      end else begin
        irq_stat_r <= irq_stat_r | ev;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= |(irq_stat_r & mask_r);
    end
  end

  // ========================================================================
  // Burst mode and adaptive lockout selection.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      burst_r <= 1'b0;
      lowered_lockout_sel <= 1'b0;
    end else if (clk_en) begin
      if (!burst_r && fb_lo_r) begin
        burst_r <= 1'b1;
      end else if (burst_r && fb_at_r) begin
        burst_r <= 1'b0;
      end
      if (fb_lo_r) begin
        lowered_lockout_sel <= 1'b1;
      end else if (fb_hi_r) begin
        lowered_lockout_sel <= 1'b0;
      end
    end
  end

  // Clamp selected while switching bursts run in burst operation.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      peak_clamp_sel <= 1'b0;
    end else if (clk_en) begin
      peak_clamp_sel <= lowered_lockout_sel && !fb_hi_r;
    end
  end

  // ========================================================================
  // Jitter square wave: equal halves give the 50 percent duty.
  logic [9:0] jit_cnt_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      jit_cnt_r <= '0;
      jitter_wave <= 1'b0;
      jitter_depth <= 8'h00;
    end else if (clk_en) begin
      jitter_depth <= ctrl_r[`FMPC_CTRL_DEPTH_HI:`FMPC_CTRL_DEPTH_LO];
      if (jit_cnt_r == 10'(JIT_HALF - 1)) begin
        jit_cnt_r <= '0;
        jitter_wave <= !jitter_wave;
      end else begin
        jit_cnt_r <= jit_cnt_r + 10'h001;
      end
    end
  end

  // ========================================================================
  // Overvoltage sample and consecutive counter, once per demag strobe.
  logic ov_hit;
  assign ov_hit = demag_r && ov_r && (ov_cnt_r == 4'(OV_TRIP - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ov_cnt_r <= '0;
      ov_seen_r <= 1'b0;
    end else if (clk_en) begin
      if (st_r != fmpc_pkg::FMPC_RUN) begin
        ov_cnt_r <= '0;
      end else if (demag_r) begin
        ov_seen_r <= ov_r;
        if (ov_r) begin
          ov_cnt_r <= ov_hit ? '0 : ov_cnt_r + 4'h1;
        end else begin
          ov_cnt_r <= '0;
        end
      end
    end
  end

  // ========================================================================
  // Sequencer: wait for turn-on, run, trip, rearm after restart level.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= fmpc_pkg::FMPC_WAIT;
    end else if (clk_en) begin
      unique case (st_r)
        fmpc_pkg::FMPC_WAIT: if (on_r) st_r <= fmpc_pkg::FMPC_RUN;
        fmpc_pkg::FMPC_RUN: begin
          if (ov_hit) begin
            st_r <= fmpc_pkg::FMPC_TRIP;
          end else if (lock_r) begin
            st_r <= fmpc_pkg::FMPC_WAIT;
          end
        end
        fmpc_pkg::FMPC_TRIP: begin
          // Both builds leave the trip only at the restart level.
          if (rst_lvl_r) begin
            st_r <= fmpc_pkg::FMPC_REARM;
          end
        end
        fmpc_pkg::FMPC_REARM: if (on_r) st_r <= fmpc_pkg::FMPC_RUN;
      endcase
    end
  end

  // Latched variant: start-up source recycled by a period counter.
  logic [15:0] hv_cnt_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hv_cnt_r <= '0;
    end else if (clk_en) begin
      if (st_r != fmpc_pkg::FMPC_TRIP ||
          hv_cnt_r == 16'(HV_PERIOD - 1)) begin
        hv_cnt_r <= '0;
      end else begin
        hv_cnt_r <= hv_cnt_r + 16'h0001;
      end
    end
  end

  // Start-up source and gate outputs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hv_startup_en <= 1'b1;
      gate_drive <= 1'b0;
    end else if (clk_en) begin
      unique case (st_r)
        fmpc_pkg::FMPC_TRIP:
          hv_startup_en <= LATCHED ? (hv_cnt_r < 16'(HV_ON)) : 1'b0;
        fmpc_pkg::FMPC_RUN: hv_startup_en <= 1'b0;
        default: hv_startup_en <= !on_r;
      endcase
      gate_drive <= req_r && !lock_r && !burst_r && ctrl_r[`FMPC_CTRL_EN]
                    && st_r == fmpc_pkg::FMPC_RUN;
    end
  end

  // Events for the interrupt register.
  always_comb begin
    ev = '0;
    ev[`FMPC_EV_BURST_IN] = clk_en && !burst_r && fb_lo_r;
    ev[`FMPC_EV_BURST_OUT] = clk_en && burst_r && fb_at_r;
    ev[`FMPC_EV_OV_TRIP] = clk_en && st_r == fmpc_pkg::FMPC_RUN && ov_hit;
    ev[`FMPC_EV_LOCKOUT] = clk_en && st_r == fmpc_pkg::FMPC_RUN && lock_r;
  end

  // ========================================================================
  // Checks.
  chk_gate_lockout: assert property (@(posedge pclk) disable iff (!presetn)
    lock_r && clk_en |=> !gate_drive) else $error("gate on in lockout");
  chk_gate_burst: assert property (@(posedge pclk) disable iff (!presetn)
    burst_r && clk_en |=> !gate_drive) else $error("gate on in burst");
  chk_burst_entry: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && fb_lo_r |=> burst_r) else $error("burst not entered");
  chk_lockout_low: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && fb_lo_r |=> lowered_lockout_sel) else $error("no low uvlo");
  chk_lockout_norm: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && fb_hi_r && !fb_lo_r |=> !lowered_lockout_sel)
    else $error("uvlo not restored");
  chk_ov_clear: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && demag_r && !ov_r |=> ov_cnt_r == 4'h0)
    else $error("counter not cleared");
  chk_ov_once: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !demag_r && st_r == fmpc_pkg::FMPC_RUN |=> $stable(ov_cnt_r))
    else $error("counter moved without strobe");
  chk_trip_hold: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == fmpc_pkg::FMPC_TRIP |=> !gate_drive) else $error("trip gate");
  chk_trip_cause: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(st_r == fmpc_pkg::FMPC_TRIP) |-> $past(ov_cnt_r) == 4'(OV_TRIP - 1))
    else $error("trip without count");
  chk_jit_half: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && jit_cnt_r != 10'(JIT_HALF - 1) |=> $stable(jitter_wave))
    else $error("jitter toggled early");
endmodule

//--- fmpc_params.svh
// Constants for the flyback mode and protection sequencer.
// Assumes inclusion by bare name from the package and design files.
`ifndef FMPC_PARAMS_SVH
`define FMPC_PARAMS_SVH
// ==========================================================================
// Register byte offsets.
`define FMPC_OFF_CTRL 12'h000
`define FMPC_OFF_STAT 12'h004
`define FMPC_OFF_IRQ 12'h008
`define FMPC_OFF_MASK 12'h00C
// ==========================================================================
// Control field positions.
`define FMPC_CTRL_EN 0
`define FMPC_CTRL_DEPTH_LO 8
`define FMPC_CTRL_DEPTH_HI 15
// Reset value of the control register: enabled, jitter depth 5 percent.
`define FMPC_CTRL_RST 32'h0000_0501
// ==========================================================================
// Timing: clock rate and jitter frequency.
`define FMPC_CLK_HZ 10000000
`define FMPC_JIT_HZ 9000
// Half period of the jitter square wave, rounded down.
`define FMPC_JIT_HALF (`FMPC_CLK_HZ / (2 * `FMPC_JIT_HZ))
// Consecutive overvoltage cycles needed to trip.
`define FMPC_OV_TRIP 4
// Period and on time of the latched-mode start-up source recycling.
`define FMPC_HV_PERIOD 10000
`define FMPC_HV_ON 5000
// Event bits of the interrupt and mask registers.
`define FMPC_EV_BURST_IN 0
`define FMPC_EV_BURST_OUT 1
`define FMPC_EV_OV_TRIP 2
`define FMPC_EV_LOCKOUT 3
`define FMPC_EV_W 4
`endif

//--- fmpc_pkg.sv
// Types shared by the flyback mode and protection sequencer.
// Assumes the constants header is present in the same folder.
`include "fmpc_params.svh"
package fmpc_pkg;
  // ========================================================================
  // Sequencer states, Gray coded along start, run, trip, restart.
  typedef enum logic [1:0] {
    FMPC_WAIT = 2'b00,
    FMPC_RUN = 2'b01,
    FMPC_TRIP = 2'b11,
    FMPC_REARM = 2'b10
  } fmpc_state_e;
endpackage

//--- fmpc_far_model.sv
// Far-side model: switching oscillator and sense-winding comparator.
// Assumes pclk and presetn from the bench and the gate output of the block.
`timescale 1ns/1ps
module fmpc_far_model #(
  parameter int PER = 8
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Gate state and the level the bench wants at demagnetization.
  input wire logic gate_drive,
  input wire logic ov_cmd,
  // Comparator outputs toward the sequencer.
  output logic demag_strobe,
  output logic sense_winding_above_ref
);
  // ========================================================================
  // Oscillator
  logic [7:0] cnt_r; // Position within the switching cycle.
  logic ran_r; // Gate was seen on during this cycle.
  logic last_w; // Last slot of the cycle.
  assign last_w = (cnt_r == 8'(PER - 1));
  // A demagnetization strobe follows only a cycle in which the gate ran.
  // The sense level is valid only with the strobe and toggles otherwise,
  // so a design sampling it at the wrong moment sees garbage.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 8'h00;
      ran_r <= 1'b0;
      demag_strobe <= 1'b0;
      sense_winding_above_ref <= 1'b0;
    end else begin
      cnt_r <= last_w ? 8'h00 : cnt_r + 8'h01;
      ran_r <= last_w ? 1'b0 : (ran_r | gate_drive);
      demag_strobe <= last_w & (ran_r | gate_drive);
      if (last_w) begin
        sense_winding_above_ref <= ov_cmd;
      end else begin
        sense_winding_above_ref <= ~sense_winding_above_ref;
      end
    end
  end
endmodule

//--- fmpc_ctrl_tb_top.sv
// Self-checking bench for the mode and protection sequencer.
// Assumes the design files and the far-side model are compiled first.
`timescale 1ns/1ps
`include "fmpc_params.svh"
module fmpc_ctrl_tb_top;
  localparam int HV_P = 20; // Short recycling period for simulation.
  localparam int HV_N = 10; // Short recycling on time.
  // ========================================================================
  // Signals
  logic pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, er, ov_cmd = 1'b0;
  logic fb_below = 1'b0, fb_at = 1'b1, fb_above = 1'b1, turn_on = 1'b0;
  logic below_lock = 1'b0, below_rst = 1'b0, sw_req = 1'b0;
  logic strobe, sense, gate, clamp, lowered, jit, hv, irq, gate_l, hv_l;
  logic [7:0] depth;
  int num_errors = 0, check_count = 0, n;
  // ========================================================================
  // Instances: auto-restart and latched variants share every input.
  fmpc_ctrl #(.HV_PERIOD(HV_P), .HV_ON(HV_N)) fmpc_ctrl_i (.pclk(pclk),
    .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .feedback_below_entry(fb_below),
    .feedback_above_exit(fb_above), .feedback_at_entry(fb_at),
    .supply_at_turn_on(turn_on), .supply_below_lockout(below_lock),
    .supply_below_restart(below_rst), .sense_winding_above_ref(sense),
    .demag_strobe(strobe), .switch_request(sw_req), .gate_drive(gate),
    .peak_clamp_sel(clamp), .lowered_lockout_sel(lowered),
    .jitter_wave(jit), .jitter_depth(depth), .hv_startup_en(hv), .irq(irq));
  fmpc_ctrl #(.LATCHED(1'b1), .HV_PERIOD(HV_P), .HV_ON(HV_N))
    fmpc_ctrl_l_i (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
    .feedback_below_entry(fb_below), .feedback_above_exit(fb_above),
    .feedback_at_entry(fb_at), .supply_at_turn_on(turn_on),
    .supply_below_lockout(below_lock), .supply_below_restart(below_rst),
    .sense_winding_above_ref(sense), .demag_strobe(strobe),
    .switch_request(sw_req), .gate_drive(gate_l), .peak_clamp_sel(),
    .lowered_lockout_sel(), .jitter_wave(), .jitter_depth(),
    .hv_startup_en(hv_l), .irq());
  fmpc_far_model fmpc_far_model_i (.pclk(pclk), .presetn(presetn),
    .gate_drive(gate), .ov_cmd(ov_cmd), .demag_strobe(strobe),
    .sense_winding_above_ref(sense));
  // ========================================================================
  // Helpers
  // Expected control word: enable set, depth in bits 15..8.
  function automatic logic [31:0] exp_ctrl(input logic [7:0] d);
    return {16'h0000, d, 8'h01};
  endfunction
  task automatic chk_bit(input logic got, input logic exp, input string m);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t %s got %b", $time, m, got);
    end
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp,
                          input string m);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // One APB transfer; waits for pready with no assumed latency.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      num_errors++;
      $display("MISMATCH %0t apb answer timed out", $time);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic settle(input int c);
    repeat (c) @(posedge pclk);
  endtask
  // Waits for a number of demagnetization strobes.
  task automatic strobes(input int c);
    repeat (c) begin
      do @(posedge pclk); while (strobe !== 1'b1);
    end
  endtask
  // Counts cycles while the jitter wave holds a level.
  task automatic run_len(input logic v);
    n = 0;
    while (jit === v && n < 2000) begin
      @(posedge pclk);
      n++;
    end
  endtask
  // Ends the run with the verdict.
  task automatic summarize();
    if (num_errors == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ========================================================================
  // Clock and watchdog
  initial begin
    forever #50 pclk = ~pclk;
  end
  initial begin
    settle(20000);
    num_errors++;
    summarize();
  end
  // ========================================================================
  // Main sequence
  initial begin
    void'($urandom(32'hA696E883));
    settle(20);
    presetn <= 1'b1;
    settle(2);
    chk_bit(hv, 1'b1, "start-up source before turn-on");
    turn_on <= 1'b1;
    sw_req <= 1'b1;
    settle(6);
    chk_bit(hv, 1'b0, "start-up source after turn-on");
    chk_bit(gate, 1'b1, "gate running");
    apb(1'b0, `FMPC_OFF_CTRL, 32'h0000_0000);
    chk_word(rd, exp_ctrl(8'h05), "ctrl reset");
    chk_word({24'h000000, depth}, 32'h0000_0005, "depth reset");
    // Random depths, then the default again.
    for (int i = 0; i < 4; i++) begin
      pwdata <= 32'h0000_0000;
      n = (i == 3) ? 5 : $urandom;
      apb(1'b1, `FMPC_OFF_CTRL, exp_ctrl(n[7:0]));
      apb(1'b0, `FMPC_OFF_CTRL, 32'h0000_0000);
      chk_word(rd, exp_ctrl(n[7:0]), "ctrl readback");
      chk_word({24'h000000, depth}, {24'h000000, n[7:0]}, "depth");
    end
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk_bit(er, 1'b1, "unmapped error");
    chk_word(rd, 32'h0000_0000, "unmapped data");
    // Jitter square wave: both half periods equal.
    run_len(1'b1);
    run_len(1'b0);
    run_len(1'b1);
    chk_word(n, `FMPC_JIT_HALF, "jitter high time");
    run_len(1'b0);
    chk_word(n, `FMPC_JIT_HALF, "jitter low time");
    // Burst entry with the interrupt unmasked (a mask bit of one enables).
    apb(1'b1, `FMPC_OFF_MASK, 32'h0000_000F);
    chk_bit(clamp, 1'b0, "clamp at full load");
    fb_above <= 1'b0;
    fb_at <= 1'b0;
    fb_below <= 1'b1;
    settle(5);
    chk_bit(gate, 1'b0, "gate in burst");
    chk_bit(lowered, 1'b1, "lowered lockout");
    chk_bit(irq, 1'b1, "burst interrupt");
    apb(1'b1, `FMPC_OFF_MASK, 32'h0000_0000);
    settle(2);
    chk_bit(irq, 1'b0, "masked interrupt");
    apb(1'b1, `FMPC_OFF_MASK, 32'h0000_000F);
    apb(1'b1, `FMPC_OFF_IRQ, 32'h0000_0001);
    apb(1'b0, `FMPC_OFF_IRQ, 32'h0000_0000);
    chk_bit(rd[0], 1'b0, "burst event cleared");
    chk_bit(irq, 1'b0, "interrupt cleared");
    fb_below <= 1'b0;
    fb_at <= 1'b1;
    settle(5);
    chk_bit(gate, 1'b1, "switching in burst");
    chk_bit(clamp, 1'b1, "fixed clamp in burst");
    fb_above <= 1'b1;
    settle(5);
    chk_bit(lowered, 1'b0, "normal lockout");
    chk_bit(clamp, 1'b0, "clamp released");
    // Overvoltage: a clean cycle breaks the run of three.
    // Align to a strobe so no capture races a change of the command.
    strobes(1);
    ov_cmd <= 1'b1;
    strobes(3);
    ov_cmd <= 1'b0;
    strobes(1);
    ov_cmd <= 1'b1;
    strobes(3);
    settle(5);
    chk_bit(gate, 1'b1, "three flagged cycles");
    strobes(1);
    ov_cmd <= 1'b0;
    settle(5);
    chk_bit(gate, 1'b0, "auto trip");
    chk_bit(gate_l, 1'b0, "latched trip");
    apb(1'b0, `FMPC_OFF_STAT, 32'h0000_0000);
    chk_bit(rd[0], 1'b1, "tripped flag");
    n = 0;
    repeat (HV_P) begin
      @(posedge pclk);
      n += (hv_l === 1'b1);
    end
    chk_word(n, HV_N, "latched recycling");
    // Turn-on without a restart dip keeps both stopped.
    turn_on <= 1'b0;
    settle(3);
    turn_on <= 1'b1;
    settle(5);
    chk_bit(gate, 1'b0, "auto waits restart");
    chk_bit(gate_l, 1'b0, "latch held");
    turn_on <= 1'b0;
    below_rst <= 1'b1;
    settle(3);
    below_rst <= 1'b0;
    settle(3);
    chk_bit(gate, 1'b0, "auto waits turn-on");
    turn_on <= 1'b1;
    settle(6);
    chk_bit(gate, 1'b1, "auto resumed");
    chk_bit(gate_l, 1'b1, "latch released");
    below_lock <= 1'b1;
    settle(4);
    chk_bit(gate, 1'b0, "lockout gate");
    summarize();
  end
endmodule
